// File: synth_cfg_pkg.sv
// Shared constants for the synthesizer configuration block: word layout,
// field positions, reset words and decoded mode encodings.
// Assumes a single core clock and a plain register port of 24-bit words.
//
// Notes on behaviour
// - Aux prescaler: bit 0 gives 8/9, 1 gives 16/17
// - Main pump polarity: 0 negative, 1 positive default
// - Aux pump polarity: 1 positive, 0 negative
// - Reference output driven only when buffer enabled
// - Doubler off: both counters see plain reference
// - Doubler on: main counter alone sees double
// - Order field: 0 fourth, 2 second, 3 third
// - Order value 1 switches the modulator off
// - Spread field: off, weak, strong, 3 reserved
// - Auto power-up clears both sleeps on frequency write
// - Low chip enable suppresses auto power-up
// - Narrow mode: numerator uses low 12 bits only
// - Wide mode: numerator is upper over lower bits
// - Narrow mode: denominator upper bits are ignored
// - Wide mode: denominator spans all 22 bits
// - Wide enable bit decides extension register programmability
package synth_cfg_pkg;

  localparam int WORD_W = 24;
  localparam int ADDR_W = 3;
  localparam int FRAC_W = 22;
  localparam int FRAC_LO_W = 12;
  localparam int FRAC_HI_W = 10;

  // Word indices on the register port.
  localparam logic [ADDR_W-1:0] IDX_FREQ = 3'h0;
  localparam logic [ADDR_W-1:0] IDX_SLEEP = 3'h1;
  localparam logic [ADDR_W-1:0] IDX_DENOM = 3'h2;
  localparam logic [ADDR_W-1:0] IDX_ACCESS = 3'h3;
  localparam logic [ADDR_W-1:0] IDX_MODE = 3'h4;
  localparam logic [ADDR_W-1:0] IDX_FRAC_EXT = 3'h5;

  // Field positions.
  localparam int FREQ_NUM_LSB = 4;
  localparam int DENOM_LSB = 4;
  localparam int SLEEP_MAIN_BIT = 22;
  localparam int SLEEP_AUX_BIT = 21;
  localparam int ACCESS_WIDE_BIT = 21;
  localparam int MODE_AUTO_WAKE_BIT = 23;
  localparam int MODE_SPREAD_LSB = 16;
  localparam int MODE_FM_LSB = 14;
  localparam int MODE_DBL_BIT = 12;
  localparam int MODE_OUTEN_BIT = 11;
  localparam int MODE_AUXPOL_BIT = 10;
  localparam int MODE_MAINPOL_BIT = 9;
  localparam int MODE_PRESC_BIT = 8;
  localparam int EXT_DEN_LSB = 14;
  localparam int EXT_NUM_LSB = 4;

  // Reset words.
  localparam logic [WORD_W-1:0] RST_ZERO = 24'h000000;
  localparam logic [WORD_W-1:0] RST_SLEEP = 24'h600000;
  localparam logic [WORD_W-1:0] RST_MODE = 24'h22C709;
  localparam logic [WORD_W-1:0] RST_FRAC_EXT = 24'h00000B;
  localparam logic [WORD_W-1:0] RST_WORD6 = 24'h00000D;
  localparam logic [WORD_W-1:0] RST_WORD7 = 24'h00090F;

  // Modulator order field values and decoded orders.
  localparam logic [1:0] FM_FOURTH = 2'h0;
  localparam logic [1:0] FM_OFF = 2'h1;
  localparam logic [1:0] FM_SECOND = 2'h2;
  localparam logic [1:0] FM_THIRD = 2'h3;
  localparam logic [2:0] ORDER_NONE = 3'h0;
  localparam logic [2:0] ORDER_2 = 3'h2;
  localparam logic [2:0] ORDER_3 = 3'h3;
  localparam logic [2:0] ORDER_4 = 3'h4;

  // Spur spreading values.
  localparam logic [1:0] SPREAD_OFF = 2'h0;
  localparam logic [1:0] SPREAD_WEAK = 2'h1;
  localparam logic [1:0] SPREAD_STRONG = 2'h2;
  localparam logic [1:0] SPREAD_RSVD = 2'h3;

  // Prescaler base moduli.
  localparam logic [4:0] PRESC_8 = 5'h08;
  localparam logic [4:0] PRESC_16 = 5'h10;

  localparam logic [FRAC_HI_W-1:0] HI_ZERO = 10'h000;

endpackage

// File: pin_level_sync.sv
// Three-stage synchroniser for a level arriving from a pin.
// Assumes the pin is asynchronous to core_clk; the filtered level moves
// only when the second and third stages agree.
`timescale 1ns/1ps
`default_nettype none
module pin_level_sync (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Pin side
  input wire logic pin,
  // Core side
  output logic level,
  output logic rise,
  output logic fall
);

  logic meta;
  logic stage2;
  logic stage3;
  logic agree;

  // The first stage feeds only the second; nothing else looks at it.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meta <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      level <= 1'b0;
    end else begin
      meta <= pin;
      stage2 <= meta;
      stage3 <= stage2;
      if (agree) begin
        level <= stage3;
      end
    end
  end

  assign agree = (stage2 == stage3);
  assign rise = agree && stage3 && !level;
  assign fall = agree && !stage3 && level;

endmodule
`default_nettype wire

// File: synth_fraction_mode_config.sv
// Configuration words of a dual fractional-N / integer-N synthesizer and
// the decode of mode, polarity, reference routing and fraction width.
// Assumes a host that writes whole 24-bit words over a one-cycle strobe
// port and reference and chip-enable pins that are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module synth_fraction_mode_config
  import synth_cfg_pkg::*;
#(
  parameter int ADDR_WIDTH = ADDR_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [ADDR_WIDTH-1:0] reg_addr,
  input wire logic [WORD_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [WORD_W-1:0] reg_rdata,
  // Pins
  input wire logic chip_enable_pin,
  input wire logic ref_input_pin,
  output logic ref_output_pin_out,
  output logic ref_output_pin_oe,
  // Reference ticks to the counters
  output logic main_ref_tick,
  output logic aux_ref_tick,
  // Loop settings
  output logic [4:0] aux_prescaler_base,
  output logic main_pump_positive,
  output logic aux_pump_positive,
  output logic main_loop_sleep,
  output logic aux_loop_sleep,
  // Modulator settings
  output logic modulator_enable,
  output logic [2:0] modulator_order,
  output logic [1:0] spur_spread_mode,
  output logic wide_fraction,
  output logic [FRAC_W-1:0] frac_numerator,
  output logic [FRAC_W-1:0] frac_denominator
);

  logic [WORD_W-1:0] cfg_word [0:7];
  logic [WORD_W-1:0] next_word [0:7];
  logic [WORD_W-1:0] next_rdata;
  logic chip_enable;
  logic ref_level;
  logic ref_rise;
  logic ref_fall;
  logic auto_wake;
  logic ext_programmable;
  logic write_ext;
  logic write_access;
  logic write_freq;
  logic next_wide;
  logic [1:0] fm_field;
  logic [1:0] spread_field;
  logic [FRAC_LO_W-1:0] num_lo;
  logic [FRAC_LO_W-1:0] den_lo;
  logic [FRAC_HI_W-1:0] num_hi;
  logic [FRAC_HI_W-1:0] den_hi;
  logic [2:0] next_order;
  logic [1:0] next_spread;
  logic [4:0] next_presc;
  logic [FRAC_W-1:0] next_num;
  logic [FRAC_W-1:0] next_den;

  // Joins the two halves of a fraction; the upper half counts only in
  // wide mode, so stale upper bits never leak into a 12-bit setting.
  function automatic logic [FRAC_W-1:0] join_fraction(
    input logic wide,
    input logic [FRAC_HI_W-1:0] hi,
    input logic [FRAC_LO_W-1:0] lo
  );
    join_fraction = {(wide ? hi : HI_ZERO), lo};
  endfunction

  function automatic logic [WORD_W-1:0] reset_word(input int idx);
    case (idx)
      1: reset_word = RST_SLEEP;
      4: reset_word = RST_MODE;
      5: reset_word = RST_FRAC_EXT;
      6: reset_word = RST_WORD6;
      7: reset_word = RST_WORD7;
      default: reset_word = RST_ZERO;
    endcase
  endfunction

  pin_level_sync ce_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin(chip_enable_pin),
    .level(chip_enable),
    .rise(),
    .fall()
  );

  pin_level_sync ref_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin(ref_input_pin),
    .level(ref_level),
    .rise(ref_rise),
    .fall(ref_fall)
  );

  // Address decode.
  assign write_freq = reg_write && (reg_addr == IDX_FREQ);
  assign write_access = reg_write && (reg_addr == IDX_ACCESS);
  assign write_ext = reg_write && (reg_addr == IDX_FRAC_EXT);
  assign next_wide = write_access ? reg_wdata[ACCESS_WIDE_BIT]
                                  : cfg_word[IDX_ACCESS][ACCESS_WIDE_BIT];
  assign ext_programmable = cfg_word[IDX_ACCESS][ACCESS_WIDE_BIT];
  assign auto_wake = write_freq && cfg_word[IDX_MODE][MODE_AUTO_WAKE_BIT]
                     && chip_enable;

  // Next value of each word. The extension word is forced to its default
  // while wide mode is off, and falls back to it when wide mode is dropped.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      next_word[i] = cfg_word[i];
      if (reg_write && (reg_addr == i[ADDR_WIDTH-1:0])) begin
        next_word[i] = reg_wdata;
      end
    end
    if (!next_wide || (write_ext && !ext_programmable)) begin
      next_word[IDX_FRAC_EXT] = RST_FRAC_EXT;
    end
    if (auto_wake) begin
      next_word[IDX_SLEEP][SLEEP_MAIN_BIT] = 1'b0;
      next_word[IDX_SLEEP][SLEEP_AUX_BIT] = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 8; i++) begin
      if (sys_rst) begin
        cfg_word[i] <= reset_word(i);
      end else begin
        cfg_word[i] <= next_word[i];
      end
    end
  end

  // Read data stand for exactly one cycle after the strobe.
  assign next_rdata = reg_read ? cfg_word[reg_addr] : RST_ZERO;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= RST_ZERO;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // Field extraction from the stored words.
  assign fm_field = cfg_word[IDX_MODE][MODE_FM_LSB +: 2];
  assign spread_field = cfg_word[IDX_MODE][MODE_SPREAD_LSB +: 2];
  assign num_lo = cfg_word[IDX_FREQ][FREQ_NUM_LSB +: FRAC_LO_W];
  assign den_lo = cfg_word[IDX_DENOM][DENOM_LSB +: FRAC_LO_W];
  assign num_hi = cfg_word[IDX_FRAC_EXT][EXT_NUM_LSB +: FRAC_HI_W];
  assign den_hi = cfg_word[IDX_FRAC_EXT][EXT_DEN_LSB +: FRAC_HI_W];

  assign next_order = (fm_field == FM_FOURTH) ? ORDER_4 :
                      (fm_field == FM_SECOND) ? ORDER_2 :
                      (fm_field == FM_THIRD) ? ORDER_3 : ORDER_NONE;
  // The reserved spreading code is treated as off rather than guessed at.
  assign next_spread = (spread_field == SPREAD_RSVD) ? SPREAD_OFF : spread_field;
  assign next_presc = cfg_word[IDX_MODE][MODE_PRESC_BIT] ? PRESC_16 : PRESC_8;
  assign next_num = join_fraction(ext_programmable, num_hi, num_lo);
  assign next_den = join_fraction(ext_programmable, den_hi, den_lo);

  // Decoded settings are registered, one cycle behind the stored word.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      aux_prescaler_base <= PRESC_16;
      main_pump_positive <= 1'b1;
      aux_pump_positive <= 1'b1;
      main_loop_sleep <= 1'b1;
      aux_loop_sleep <= 1'b1;
      modulator_enable <= 1'b1;
      modulator_order <= ORDER_3;
      spur_spread_mode <= SPREAD_STRONG;
      wide_fraction <= 1'b0;
      frac_numerator <= '0;
      frac_denominator <= '0;
    end else begin
      aux_prescaler_base <= next_presc;
      main_pump_positive <= cfg_word[IDX_MODE][MODE_MAINPOL_BIT];
      aux_pump_positive <= cfg_word[IDX_MODE][MODE_AUXPOL_BIT];
      main_loop_sleep <= cfg_word[IDX_SLEEP][SLEEP_MAIN_BIT];
      aux_loop_sleep <= cfg_word[IDX_SLEEP][SLEEP_AUX_BIT];
      modulator_enable <= (fm_field != FM_OFF);
      modulator_order <= next_order;
      spur_spread_mode <= next_spread;
      wide_fraction <= ext_programmable;
      frac_numerator <= next_num;
      frac_denominator <= next_den;
    end
  end

  // Reference routing. The doubled rate is made from both edges of the
  // synchronised reference, so it is only as clean as the sampling allows.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      main_ref_tick <= 1'b0;
      aux_ref_tick <= 1'b0;
      ref_output_pin_out <= 1'b0;
      ref_output_pin_oe <= 1'b0;
    end else begin
      main_ref_tick <= ref_rise
                       || (ref_fall && cfg_word[IDX_MODE][MODE_DBL_BIT]);
      aux_ref_tick <= ref_rise;
      ref_output_pin_out <= ref_level && cfg_word[IDX_MODE][MODE_OUTEN_BIT];
      ref_output_pin_oe <= cfg_word[IDX_MODE][MODE_OUTEN_BIT];
    end
  end

  // Decoded outputs trail the stored word by one edge, so a written word
  // shows on them two edges after the strobe is sampled.
  sequence wake_write_s;
    write_freq && cfg_word[IDX_MODE][MODE_AUTO_WAKE_BIT] && chip_enable;
  endsequence

  sequence mode_write_s;
    reg_write && (reg_addr == IDX_MODE);
  endsequence

  sequence both_awake_s;
    !main_loop_sleep && !aux_loop_sleep;
  endsequence

  auto_wake_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    wake_write_s |-> ##2 both_awake_s)
    else $error("auto power-up did not wake both loops");

  ce_block_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    write_freq && !chip_enable && cfg_word[IDX_SLEEP][SLEEP_MAIN_BIT]
    |=> cfg_word[IDX_SLEEP][SLEEP_MAIN_BIT])
    else $error("frequency write woke the loop with chip enable low");

  prescaler_sel_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    aux_prescaler_base == ($past(cfg_word[IDX_MODE][MODE_PRESC_BIT]) ? PRESC_16 : PRESC_8))
    else $error("prescaler base does not follow its select bit");

  main_pol_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    mode_write_s |-> ##2 main_pump_positive == $past(reg_wdata[MODE_MAINPOL_BIT], 2))
    else $error("main pump polarity wrong");

  ref_tristate_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !ref_output_pin_oe |-> !ref_output_pin_out)
    else $error("reference output driven while disabled");

  aux_single_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    main_ref_tick && !aux_ref_tick |-> $past(cfg_word[IDX_MODE][MODE_DBL_BIT]))
    else $error("extra main tick without doubler");

  order_off_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $past(fm_field) == FM_OFF |-> !modulator_enable && modulator_order == ORDER_NONE)
    else $error("modulator not off for order value 1");

  order_map_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $past(fm_field) == FM_SECOND |-> modulator_order == ORDER_2)
    else $error("second order not selected");

  narrow_num_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !wide_fraction |-> frac_numerator[FRAC_W-1:FRAC_LO_W] == HI_ZERO)
    else $error("upper numerator bits used in narrow mode");

  ext_default_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !ext_programmable |-> cfg_word[IDX_FRAC_EXT] == RST_FRAC_EXT)
    else $error("extension word left its default in narrow mode");

  wide_den_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    wide_fraction |-> frac_denominator == $past({den_hi, den_lo}))
    else $error("wide denominator not formed from both halves");

  aux_pol_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    mode_write_s |-> ##2 aux_pump_positive == $past(reg_wdata[MODE_AUXPOL_BIT], 2))
    else $error("aux pump polarity wrong");

  order_third_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $past(fm_field) == FM_THIRD |-> modulator_order == ORDER_3)
    else $error("third order not selected");

  order_fourth_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $past(fm_field) == FM_FOURTH |-> modulator_order == ORDER_4)
    else $error("fourth order not selected");

  mod_on_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $past(fm_field) != FM_OFF |-> modulator_enable)
    else $error("modulator off for a fractional order");

  spread_map_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $past(spread_field) != SPREAD_RSVD |-> spur_spread_mode == $past(spread_field))
    else $error("spreading mode does not follow its field");

  ref_follow_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    ref_output_pin_oe |-> ref_output_pin_out == $past(ref_level))
    else $error("reference output does not copy the input");

  oe_follow_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    ref_output_pin_oe == $past(cfg_word[IDX_MODE][MODE_OUTEN_BIT]))
    else $error("reference output enable does not follow its bit");

  aux_tick_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    aux_ref_tick == $past(ref_rise))
    else $error("aux tick not one per reference rise");

  main_plain_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !$past(cfg_word[IDX_MODE][MODE_DBL_BIT]) |-> main_ref_tick == aux_ref_tick)
    else $error("main tick differs from aux tick without doubler");

  wide_num_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    wide_fraction |-> frac_numerator == $past({num_hi, num_lo}))
    else $error("wide numerator not formed from both halves");

  narrow_den_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !wide_fraction |-> frac_denominator[FRAC_W-1:FRAC_LO_W] == HI_ZERO)
    else $error("upper denominator bits used in narrow mode");

  wide_flag_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    wide_fraction == $past(cfg_word[IDX_ACCESS][ACCESS_WIDE_BIT]))
    else $error("wide flag does not follow the access word");

  ext_refuse_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    write_ext && !ext_programmable |=> cfg_word[IDX_FRAC_EXT] == RST_FRAC_EXT)
    else $error("extension word accepted in narrow mode");

  wake_off_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    write_freq && !cfg_word[IDX_MODE][MODE_AUTO_WAKE_BIT]
    && cfg_word[IDX_SLEEP][SLEEP_AUX_BIT] |=> cfg_word[IDX_SLEEP][SLEEP_AUX_BIT])
    else $error("frequency write woke the loop without auto power-up");

  aux_ce_block_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    write_freq && !chip_enable && cfg_word[IDX_SLEEP][SLEEP_AUX_BIT]
    |=> cfg_word[IDX_SLEEP][SLEEP_AUX_BIT])
    else $error("frequency write woke the aux loop with chip enable low");

  rd_data_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    reg_read |=> reg_rdata == $past(cfg_word[reg_addr]))
    else $error("read data is not the stored word");

  rd_idle_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !reg_read |=> reg_rdata == RST_ZERO)
    else $error("read data present without a read");

endmodule
`default_nettype wire

// File: host_word_writer.sv
// Host controller model that sends whole configuration words on the port.
// Assumes the caller sits in the bench's clock domain; one strobe per call, none for a mode word with the reserved spread code.
`timescale 1ns/1ps
`default_nettype none
module host_word_writer
  import synth_cfg_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Register port
  output var logic [ADDR_W-1:0] reg_addr,
  output var logic [WORD_W-1:0] reg_wdata,
  output var logic reg_write,
  output var logic reg_read,
  input wire logic [WORD_W-1:0] reg_rdata
);
  initial begin
    reg_addr = '0;
    reg_wdata = '0;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end

  task automatic write_word(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
    // A real host never sends the reserved spread code, so neither do we.
    if (a == IDX_MODE && d[MODE_SPREAD_LSB+:2] == SPREAD_RSVD) return;
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
    reg_wdata <= ~d;
  endtask

  task automatic read_word(input logic [ADDR_W-1:0] a, output logic [WORD_W-1:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// File: tb_synth_fraction_mode_config.sv
// Self-checking bench for the configuration decode block.
// Assumes the host model drives the register port; pins are driven here.
`timescale 1ns/1ps
`default_nettype none
module tb_synth_fraction_mode_config
  import synth_cfg_pkg::*;
;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic chip_enable_pin = 1'b1;
  logic ref_input_pin = 1'b0;
  logic [ADDR_W-1:0] reg_addr;
  logic [WORD_W-1:0] reg_wdata, reg_rdata, rd;
  logic reg_write, reg_read, ref_out, ref_oe, main_tick, aux_tick;
  logic [4:0] presc;
  logic main_pos, aux_pos, main_sleep, aux_sleep, mod_en, wide;
  logic [2:0] order;
  logic [1:0] spread;
  logic [FRAC_W-1:0] num, den;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  int main_cnt = 0;
  int aux_cnt = 0;

  initial begin
    forever #2.5 core_clk = ~core_clk;
  end

  host_word_writer host_u (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));

  synth_fraction_mode_config dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .chip_enable_pin(chip_enable_pin), .ref_input_pin(ref_input_pin),
    .ref_output_pin_out(ref_out), .ref_output_pin_oe(ref_oe), .main_ref_tick(main_tick),
    .aux_ref_tick(aux_tick), .aux_prescaler_base(presc), .main_pump_positive(main_pos),
    .aux_pump_positive(aux_pos), .main_loop_sleep(main_sleep), .aux_loop_sleep(aux_sleep),
    .modulator_enable(mod_en), .modulator_order(order), .spur_spread_mode(spread),
    .wide_fraction(wide), .frac_numerator(num), .frac_denominator(den));

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    main_cnt <= main_cnt + int'(main_tick);
    aux_cnt <= aux_cnt + int'(aux_tick);
    if (cyc == 20000) begin
      n_errors++;
      conclude();
    end
  end

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic settle();
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  task automatic t_reset();
    #1;
    check("presc", 24'(presc), 24'h10);
    check("main_pol", 24'(main_pos), 24'h1);
    check("order", 24'(order), 24'h3);
    check("wide", 24'(wide), 24'h0);
  endtask

  task automatic t_modes();
    logic [1:0] f, spread_code;
    logic [2:0] prev;
    logic [WORD_W-1:0] w;
    prev = 3'h3;
    for (int i = 0; i < 4; i++) begin
      f = 2'(i);
      spread_code = (f == FM_THIRD) ? SPREAD_OFF : f;
      // Aux polarity is kept positive except once to see the negative code.
      w = 24'h200009 | (24'(spread_code) << 16) | (24'(f) << 14) | (24'(f[1]) << 9) |
          (24'(f != 2'h2) << 10) | (24'(f[0]) << 8);
      host_u.write_word(IDX_MODE, w);
      #1;
      check("order_early", 24'(order), 24'(prev));
      settle();
      prev = (f == FM_FOURTH) ? ORDER_4 : (f == FM_OFF) ? ORDER_NONE : 3'(f);
      check("order", 24'(order), 24'(prev));
      check("mod_en", 24'(mod_en), 24'(f != FM_OFF));
      check("spread", 24'(spread), 24'(spread_code));
      check("presc", 24'(presc), f[0] ? 24'h10 : 24'h08);
      check("main_pol", 24'(main_pos), 24'(f[1]));
      check("aux_pol", 24'(aux_pos), 24'(f != 2'h2));
    end
    host_u.read_word(IDX_MODE, rd);
    check("rdata", rd, w);
    @(posedge core_clk);
    #1;
    check("rdata_idle", reg_rdata, 24'h0);
  endtask

  task automatic t_fraction();
    host_u.write_word(IDX_FREQ, 24'h00ABC0);
    host_u.write_word(IDX_DENOM, 24'h003E80);
    host_u.write_word(IDX_FRAC_EXT, 24'hFFFFFF);
    settle();
    check("num_narrow", 24'(num), 24'h000ABC);
    check("den_narrow", 24'(den), 24'h0003E8);
    check("sleep_no_auto_power_up", 24'(main_sleep), 24'h1);
    host_u.read_word(IDX_FRAC_EXT, rd);
    check("ext_refused", rd, RST_FRAC_EXT);
    host_u.write_word(IDX_ACCESS, 24'h300000);
    host_u.write_word(IDX_FRAC_EXT, 24'hFFFFFF);
    host_u.write_word(IDX_FREQ, 24'h00FFF0);
    host_u.write_word(IDX_DENOM, 24'h00FFF0);
    settle();
    check("wide", 24'(wide), 24'h1);
    check("num_wide", 24'(num), 24'h3FFFFF);
    check("den_wide", 24'(den), 24'h3FFFFF);
    host_u.write_word(IDX_FRAC_EXT, 24'h00000B);
    host_u.write_word(IDX_FREQ, 24'h000050);
    settle();
    check("num_small", 24'(num), 24'h000005);
    host_u.write_word(IDX_FRAC_EXT, 24'hFFFFFF);
    host_u.write_word(IDX_ACCESS, 24'h100000);
    settle();
    check("num_back", 24'(num), 24'h000005);
    check("den_back", 24'(den), 24'h000FFF);
  endtask

  task automatic t_power();
    host_u.write_word(IDX_MODE, 24'hA2C709);
    chip_enable_pin <= 1'b0;
    repeat (6) @(posedge core_clk);
    host_u.write_word(IDX_FREQ, 24'h000010);
    settle();
    check("sleep_ce_low", 24'({main_sleep, aux_sleep}), 24'h3);
    chip_enable_pin <= 1'b1;
    repeat (6) @(posedge core_clk);
    host_u.write_word(IDX_FREQ, 24'h000010);
    settle();
    check("sleep_woken", 24'({main_sleep, aux_sleep}), 24'h0);
  endtask

  task automatic t_ref(input logic dbl, input logic oen);
    int m0, a0;
    host_u.write_word(IDX_MODE, 24'h22C709 ^ (24'(dbl) << 12) ^ (24'(oen) << 11));
    settle();
    m0 = main_cnt;
    a0 = aux_cnt;
    repeat (8) begin
      repeat (10) @(posedge core_clk);
      ref_input_pin <= ~ref_input_pin;
    end
    repeat (10) @(posedge core_clk);
    #1;
    check("oe", 24'(ref_oe), 24'(oen));
    if (oen) check("ref_out", 24'(ref_out), 24'(ref_input_pin));
    check("aux_ticks", 24'(aux_cnt - a0), 24'h4);
    check("main_ticks", 24'(main_cnt - m0), dbl ? 24'h8 : 24'h4);
  endtask

  task automatic conclude();
    if (n_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_modes();
    t_fraction();
    t_power();
    t_ref(1'b0, 1'b0);
    t_ref(1'b1, 1'b1);
    host_u.read_word(3'h6, rd);
    check("word6", rd, RST_WORD6);
    conclude();
  end
endmodule
`default_nettype wire
